/* File: src/prcr_top.sv */
// Purpose: I2C target holding configuration of two power resources.
// Assumes: SCL and SDA arrive asynchronously and are oversampled.
// Notes: Register pointer auto-increments on each data byte.
`timescale 1ns/1ns
// Contract
// (RULE1) Bits 7:5 are a processor group mask; 111 means all; resets to 7.
// (RULE2) Warm reset forces mask to 111 or keeps it; always restores voltage default.
// (RULE3) Policy bit 0 forces mask to all groups; 1 keeps the mask.
// (RULE4) Group register bits 3:0 show resource state, read-only, reset 0.
// (RULE5) Class bits 4:3 are secondary class, reset 0; bits 7:5 read zero.
// (RULE6) Reset-output primary class bits 2:0 are writable, reset 6.
// (RULE7) Main-reference primary class bits 2:0 are writable, reset 0.
// (RULE8) Map bits 7:4 give the state taken when off mode is requested.
// (RULE9) Map bits 3:0 give the state taken when sleep is requested; reset 8.
// (RULE10) Maps act only in sleep or off mode, not in active mode.
// (RULE11) Writes change only writable fields; read-only and reserved bits keep values.
module prcr_top (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic scl_pin,
   input wire logic sda_pin_in,
   output logic sda_pin_out,
   output logic sda_pin_oe,
   input wire logic [1:0] sys_mode_pin,
   input wire logic [2:0] group_active_pin,
   input wire logic warm_reset_pin,
   output logic [3:0] reset_output_state,
   output logic [3:0] main_ref_state,
   output logic reset_output_vsel_restore,
   output logic main_ref_vsel_restore
);
   import prcr_pkg::*;

   localparam int SYNC_W = 8;

   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic scl_s;
   logic sda_s;
   logic warm_s;
   logic [1:0] mode_s;
   logic [2:0] grp_act_s;
   logic scl_d;
   logic sda_d;
   logic warm_d;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic warm_edge;

   prcr_i2c_state_t st;
   logic [7:0] shift;
   logic [3:0] cnt;
   logic [7:0] ptr;
   logic nack;
   logic wr_pulse;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic byte_done;
   logic last_rd_bit;
   logic wr_rst_grp;
   logic wr_rst_cls;
   logic wr_rst_map;
   logic wr_ref_grp;
   logic wr_ref_cls;
   logic wr_ref_map;

   logic [7:0] rst_grp_reg;
   logic [7:0] rst_cls_reg;
   logic [7:0] rst_map_reg;
   logic [7:0] ref_grp_reg;
   logic [7:0] ref_cls_reg;
   logic [7:0] ref_map_reg;

   // Two-stage synchroniser for every pin input
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a <= {SYNC_W{1'b1}};
         sync_b <= {SYNC_W{1'b1}};
      end else begin
         sync_a <= {scl_pin, sda_pin_in, warm_reset_pin, sys_mode_pin, group_active_pin};
         sync_b <= sync_a;
      end
   end

   assign scl_s = sync_b[7];
   assign sda_s = sync_b[6];
   assign warm_s = sync_b[5];
   assign mode_s = sync_b[4:3];
   assign grp_act_s = sync_b[2:0];

   // Delayed copies for edge detection
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         warm_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         warm_d <= warm_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
   assign warm_edge = warm_s & ~warm_d;

   // Bit counter end points
   assign byte_done = (cnt == PRCR_BYTE_BITS);
   assign last_rd_bit = (cnt == PRCR_LAST_BIT);

   // Write strobe per register
   assign wr_rst_grp = wr_pulse && (wr_addr == PRCR_OFF_RST_GRP);
   assign wr_rst_cls = wr_pulse && (wr_addr == PRCR_OFF_RST_CLS);
   assign wr_rst_map = wr_pulse && (wr_addr == PRCR_OFF_RST_MAP);
   assign wr_ref_grp = wr_pulse && (wr_addr == PRCR_OFF_REF_GRP);
   assign wr_ref_cls = wr_pulse && (wr_addr == PRCR_OFF_REF_CLS);
   assign wr_ref_map = wr_pulse && (wr_addr == PRCR_OFF_REF_MAP);

   // Register read mux, unmapped reads zero
   always_comb begin
      unique case (ptr)
         PRCR_OFF_RST_GRP: rd_data = rst_grp_reg;
         PRCR_OFF_RST_CLS: rd_data = rst_cls_reg;
         PRCR_OFF_RST_MAP: rd_data = rst_map_reg;
         PRCR_OFF_REF_GRP: rd_data = ref_grp_reg;
         PRCR_OFF_REF_CLS: rd_data = ref_cls_reg;
         PRCR_OFF_REF_MAP: rd_data = ref_map_reg;
         default: rd_data = 8'h00;
      endcase
   end

   // Open-drain SDA only ever pulls low
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_pin_out <= 1'b0;
      end else begin
         sda_pin_out <= 1'b0;
      end
   end

   // I2C target protocol engine
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= PRCR_ST_IDLE;
         shift <= 8'h00;
         cnt <= 4'h0;
         ptr <= 8'h00;
         nack <= 1'b0;
         sda_pin_oe <= 1'b0;
         wr_pulse <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_pulse <= 1'b0;
         if (bus_start) begin
            st <= PRCR_ST_ADDR;
            cnt <= 4'h0;
            sda_pin_oe <= 1'b0;
         end else if (bus_stop) begin
            st <= PRCR_ST_IDLE;
            sda_pin_oe <= 1'b0;
         end else begin
            unique case (st)
               PRCR_ST_IDLE: begin
                  sda_pin_oe <= 1'b0;
               end
               PRCR_ST_ADDR, PRCR_ST_PTR, PRCR_ST_WDATA: begin
                  if (scl_rise && !byte_done) begin
                     shift <= {shift[6:0], sda_s};
                     cnt <= 4'(cnt + 4'h1);
                  end else if (scl_fall && byte_done) begin
                     cnt <= 4'h0;
                     if (st == PRCR_ST_ADDR) begin
                        if (shift[7:1] == PRCR_I2C_ADDR) begin
                           sda_pin_oe <= 1'b1;
                           nack <= shift[0];
                           st <= PRCR_ST_ADDR_ACK;
                        end else begin
                           st <= PRCR_ST_IDLE;
                        end
                     end else if (st == PRCR_ST_PTR) begin
                        ptr <= shift;
                        sda_pin_oe <= 1'b1;
                        st <= PRCR_ST_PTR_ACK;
                     end else begin
                        wr_pulse <= 1'b1;
                        wr_addr <= ptr;
                        wr_data <= shift;
                        sda_pin_oe <= 1'b1;
                        st <= PRCR_ST_WDATA_ACK;
                     end
                  end
               end
               PRCR_ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     cnt <= 4'h0;
                     if (nack) begin
                        shift <= rd_data;
                        sda_pin_oe <= ~rd_data[7];
                        st <= PRCR_ST_RDATA;
                     end else begin
                        sda_pin_oe <= 1'b0;
                        st <= PRCR_ST_PTR;
                     end
                  end
               end
               PRCR_ST_PTR_ACK: begin
                  if (scl_fall) begin
                     sda_pin_oe <= 1'b0;
                     st <= PRCR_ST_WDATA;
                  end
               end
               PRCR_ST_WDATA_ACK: begin
                  if (scl_fall) begin
                     sda_pin_oe <= 1'b0;
                     ptr <= 8'(ptr + 8'h01);
                     st <= PRCR_ST_WDATA;
                  end
               end
               PRCR_ST_RDATA: begin
                  if (scl_fall) begin
                     if (last_rd_bit) begin
                        sda_pin_oe <= 1'b0;
                        ptr <= 8'(ptr + 8'h01);
                        st <= PRCR_ST_RDATA_ACK;
                     end else begin
                        shift <= {shift[6:0], 1'b0};
                        sda_pin_oe <= ~shift[6];
                        cnt <= 4'(cnt + 4'h1);
                     end
                  end
               end
               PRCR_ST_RDATA_ACK: begin
                  if (scl_rise) begin
                     nack <= sda_s;
                  end else if (scl_fall) begin
                     cnt <= 4'h0;
                     if (nack) begin
                        st <= PRCR_ST_IDLE;
                     end else begin
                        shift <= rd_data;
                        sda_pin_oe <= ~rd_data[7];
                        st <= PRCR_ST_RDATA;
                     end
                  end
               end
               default: begin
                  st <= PRCR_ST_IDLE;
                  cnt <= 4'h0;
                  sda_pin_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // Chip reset output resource
   prcr_resource #(
      .CLS_RESET(PRCR_RST_CLS_RST) // RULE6
   ) u_reset_output (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wr_grp(wr_rst_grp),
      .wr_cls(wr_rst_cls),
      .wr_map(wr_rst_map),
      .wr_data(wr_data),
      .warm_edge(warm_edge),
      .sys_mode(mode_s),
      .group_active(grp_act_s),
      .grp_reg(rst_grp_reg),
      .cls_reg(rst_cls_reg),
      .map_reg(rst_map_reg),
      .state(reset_output_state),
      .vsel_restore(reset_output_vsel_restore)
   );

   // Main voltage reference resource
   prcr_resource #(
      .CLS_RESET(PRCR_REF_CLS_RST) // RULE7
   ) u_main_ref (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wr_grp(wr_ref_grp),
      .wr_cls(wr_ref_cls),
      .wr_map(wr_ref_map),
      .wr_data(wr_data),
      .warm_edge(warm_edge),
      .sys_mode(mode_s),
      .group_active(grp_act_s),
      .grp_reg(ref_grp_reg),
      .cls_reg(ref_cls_reg),
      .map_reg(ref_map_reg),
      .state(main_ref_state),
      .vsel_restore(main_ref_vsel_restore)
   );
endmodule

/* File: src/prcr_pkg.sv */
// Purpose: Constants and types for the power resource configuration bank.
// Assumes: 8-bit registers reached over an I2C target port.
// Notes: State codes and the last map offset are local choices.
package prcr_pkg;
   // I2C target address and register offsets
   localparam logic [6:0] PRCR_I2C_ADDR = 7'h4B;
   localparam logic [7:0] PRCR_OFF_RST_GRP = 8'hEC;
   localparam logic [7:0] PRCR_OFF_RST_CLS = 8'hED;
   localparam logic [7:0] PRCR_OFF_RST_MAP = 8'hEE;
   localparam logic [7:0] PRCR_OFF_REF_GRP = 8'hEF;
   localparam logic [7:0] PRCR_OFF_REF_CLS = 8'hF0;
   localparam logic [7:0] PRCR_OFF_REF_MAP = 8'hF1;

   // Field positions
   localparam int PRCR_MASK_MSB = 7;
   localparam int PRCR_MASK_LSB = 5;
   localparam int PRCR_POLICY_BIT = 4;
   localparam int PRCR_CLS2_MSB = 4;
   localparam int PRCR_CLS2_LSB = 3;
   localparam int PRCR_CLS_MSB = 2;
   localparam int PRCR_MAP_OFF_MSB = 7;
   localparam int PRCR_MAP_OFF_LSB = 4;
   localparam int PRCR_MAP_SLP_MSB = 3;

   // Values after reset
   localparam logic [2:0] PRCR_MASK_RST = 3'h7;
   localparam logic [2:0] PRCR_MASK_ALL = 3'h7;
   localparam logic PRCR_POLICY_RST = 1'b0;
   localparam logic [3:0] PRCR_STATE_RST = 4'h0;
   localparam logic [1:0] PRCR_CLS2_RST = 2'h0;
   localparam logic [2:0] PRCR_RST_CLS_RST = 3'h6;
   localparam logic [2:0] PRCR_REF_CLS_RST = 3'h0;
   localparam logic [3:0] PRCR_MAP_OFF_RST = 4'h0;
   localparam logic [3:0] PRCR_MAP_SLP_RST = 4'h8;

   // Resource state codes
   localparam logic [3:0] PRCR_STATE_OFF = 4'h0;
   localparam logic [3:0] PRCR_STATE_ACTIVE = 4'hE;

   // System mode request codes
   localparam logic [1:0] PRCR_MODE_ACTIVE = 2'h0;
   localparam logic [1:0] PRCR_MODE_SLEEP = 2'h1;

   // Input synchroniser depth and bit count of one byte
   localparam int PRCR_SYNC_STAGES = 2;
   localparam logic [3:0] PRCR_BYTE_BITS = 4'h8;
   localparam logic [3:0] PRCR_LAST_BIT = 4'h7;

   typedef enum logic [3:0] {
      PRCR_ST_IDLE,
      PRCR_ST_ADDR,
      PRCR_ST_ADDR_ACK,
      PRCR_ST_PTR,
      PRCR_ST_PTR_ACK,
      PRCR_ST_WDATA,
      PRCR_ST_WDATA_ACK,
      PRCR_ST_RDATA,
      PRCR_ST_RDATA_ACK
   } prcr_i2c_state_t;
endpackage

/* File: src/prcr_resource.sv */
// Purpose: Group, class and sleep/off map registers of one power resource.
// Assumes: Write strobes already decoded; inputs synchronous to ref_clk.
// Notes: Warm reset with policy bit 0 beats a host write to the group mask.
`timescale 1ns/1ns
module prcr_resource #(
   parameter logic [2:0] CLS_RESET = 3'h0
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic wr_grp,
   input wire logic wr_cls,
   input wire logic wr_map,
   input wire logic [7:0] wr_data,
   input wire logic warm_edge,
   input wire logic [1:0] sys_mode,
   input wire logic [2:0] group_active,
   output logic [7:0] grp_reg,
   output logic [7:0] cls_reg,
   output logic [7:0] map_reg,
   output logic [3:0] state,
   output logic vsel_restore
);
   import prcr_pkg::*;

   logic [2:0] mask;
   logic policy;
   logic [1:0] cls2;
   logic [2:0] cls;
   logic [3:0] off_map;
   logic [3:0] sleep_map;

   // Group mask with warm reset override
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mask <= PRCR_MASK_RST; // RULE1
      end else if (warm_edge && (policy == 1'b0)) begin
         mask <= PRCR_MASK_ALL; // RULE2 RULE3
      end else if (wr_grp) begin
         mask <= wr_data[PRCR_MASK_MSB:PRCR_MASK_LSB]; // RULE1
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         policy <= PRCR_POLICY_RST;
      end else if (wr_grp) begin
         policy <= wr_data[PRCR_POLICY_BIT]; // RULE2
      end
   end

   // Voltage-select default restore on any warm reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         vsel_restore <= 1'b0;
      end else begin
         vsel_restore <= warm_edge; // RULE2 RULE3
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cls2 <= PRCR_CLS2_RST;
         cls <= CLS_RESET; // RULE6 RULE7
      end else if (wr_cls) begin
         cls2 <= wr_data[PRCR_CLS2_MSB:PRCR_CLS2_LSB]; // RULE5
         cls <= wr_data[PRCR_CLS_MSB:0]; // RULE6 RULE7
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         off_map <= PRCR_MAP_OFF_RST;
         sleep_map <= PRCR_MAP_SLP_RST;
      end else if (wr_map) begin
         off_map <= wr_data[PRCR_MAP_OFF_MSB:PRCR_MAP_OFF_LSB]; // RULE8
         sleep_map <= wr_data[PRCR_MAP_SLP_MSB:0]; // RULE9
      end
   end

   // Resource state from system mode
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= PRCR_STATE_RST; // RULE4
      end else if (sys_mode == PRCR_MODE_ACTIVE) begin
         state <= ((mask & group_active) != 3'h0) ? PRCR_STATE_ACTIVE
                                                  : PRCR_STATE_OFF; // RULE10
      end else if (sys_mode == PRCR_MODE_SLEEP) begin
         state <= sleep_map; // RULE9
      end else begin
         state <= off_map; // RULE8
      end
   end

   // Read views, reserved bits zero
   assign grp_reg = {mask, policy, state}; // RULE4 RULE11
   assign cls_reg = {3'h0, cls2, cls}; // RULE5 RULE11
   assign map_reg = {off_map, sleep_map};
endmodule

/* File: verification/prcr_top_sva.sv */
// Purpose: Port checker for the power resource configuration bank.
// Assumes: One clock domain; pins held well past sync latency.
// Notes: Latencies checked as short bounded windows.
`timescale 1ns/1ns
module prcr_top_sva (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic scl_pin,
   input wire logic sda_pin_out,
   input wire logic sda_pin_oe,
   input wire logic [1:0] sys_mode_pin,
   input wire logic [2:0] group_active_pin,
   input wire logic warm_reset_pin,
   input wire logic [3:0] reset_output_state,
   input wire logic [3:0] main_ref_state,
   input wire logic reset_output_vsel_restore,
   input wire logic main_ref_vsel_restore
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_vsel_pair;
      reset_output_vsel_restore == main_ref_vsel_restore;
   endproperty
   a_vsel_pair: assert property (p_vsel_pair) else $error("restore pulses differ");
   property p_vsel_once;
      reset_output_vsel_restore |=> !reset_output_vsel_restore;
   endproperty
   a_vsel_once: assert property (p_vsel_once) else $error("restore pulse too long");
   property p_vsel_cause;
      $rose(warm_reset_pin) |-> ##[2:6] reset_output_vsel_restore;
   endproperty
   a_vsel_cause: assert property (p_vsel_cause) else $error("no restore pulse");
   property p_vsel_src;
      reset_output_vsel_restore |-> $past(warm_reset_pin, 2) && !$past(warm_reset_pin, 8);
   endproperty
   a_vsel_src: assert property (p_vsel_src) else $error("restore without warm edge");
   property p_active_code;
      (sys_mode_pin == 2'h0) [*8] |-> reset_output_state inside {4'h0, 4'hE}
         && main_ref_state inside {4'h0, 4'hE};
   endproperty
   a_active_code: assert property (p_active_code) else $error("map used in active");
   property p_no_group;
      (sys_mode_pin == 2'h0 && group_active_pin == 3'h0) [*8] |->
         reset_output_state == 4'h0 && main_ref_state == 4'h0;
   endproperty
   a_no_group: assert property (p_no_group) else $error("active without group");
   property p_oe_rise;
      $rose(sda_pin_oe) |-> !scl_pin;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("data driven in clock high");
   property p_out_low;
      sda_pin_oe |-> !sda_pin_out;
   endproperty
   a_out_low: assert property (p_out_low) else $error("data line driven high");
endmodule
bind prcr_top prcr_top_sva u_sva (.ref_clk(ref_clk), .reset_n(reset_n), .scl_pin(scl_pin),
   .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .sys_mode_pin(sys_mode_pin),
   .group_active_pin(group_active_pin), .warm_reset_pin(warm_reset_pin),
   .reset_output_state(reset_output_state), .main_ref_state(main_ref_state),
   .reset_output_vsel_restore(reset_output_vsel_restore),
   .main_ref_vsel_restore(main_ref_vsel_restore));

/* File: verification/prcr_host.sv */
// Purpose: I2C host model for the configuration bank.
// Assumes: SDA pulled up; each SCL phase of a bit lasts 10 ref_clk; start/stop high phase lasts 20.
// Notes: Drives only just after a ref_clk rise.
`timescale 1ns/1ns
module prcr_host (
   input wire logic ref_clk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drv
);
   import prcr_pkg::*;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      tick(5);
      sda_drv <= b;
      tick(5);
      scl <= 1'b1;
      tick(10);
      r = sda_wire;
      scl <= 1'b0;
   endtask
   // Start is cond(1,0), stop is cond(0,1)
   task automatic cond(input logic a, input logic b);
      tick(5);
      sda_drv <= a;
      tick(5);
      scl <= 1'b1;
      tick(10);
      sda_drv <= b;
      tick(10);
      if (!b) scl <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ack_in, r);
      ack = !r;
   endtask
   task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d[$], output logic ok);
      logic [7:0] q;
      logic a;
      cond(1'b1, 1'b0);
      xfer({PRCR_I2C_ADDR, 1'b0}, 1'b1, q, ok);
      xfer(ptr, 1'b1, q, a);
      ok &= a;
      foreach (d[i]) begin
         xfer(d[i], 1'b1, q, a);
         ok &= a;
      end
      cond(1'b0, 1'b1);
   endtask
   task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
      logic [7:0] b;
      logic a;
      q = {};
      cond(1'b1, 1'b0);
      xfer({PRCR_I2C_ADDR, 1'b0}, 1'b1, b, a);
      xfer(ptr, 1'b1, b, a);
      cond(1'b1, 1'b0);
      xfer({PRCR_I2C_ADDR, 1'b1}, 1'b1, b, a);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, i == n - 1, b, a);
         q.push_back(b);
      end
      cond(1'b0, 1'b1);
   endtask
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the configuration bank.
// Assumes: Host model on the I2C pins; mode pins driven here.
// Notes: Expected values come from reset and written values.
`timescale 1ns/1ns
module tb;
   import prcr_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] sys_mode = 2'h0;
   logic [2:0] grp_act = 3'h0;
   logic warm = 1'b0;
   logic scl, sda_drv, sda_oe, ok;
   logic [3:0] rst_st, ref_st;
   logic [7:0] q[$];
   wire sda_wire = sda_drv & ~sda_oe;
   int err_count = 0;
   int tests_run = 0;
   logic rst_vsel, ref_vsel;
   int vsel_rst_cnt = 0;
   int vsel_ref_cnt = 0;
   logic [1:0] m_tab[6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
   logic [2:0] g_tab[6] = '{3'h1, 3'h2, 3'h2, 3'h0, 3'h0, 3'h1};
   logic [3:0] r_tab[6] = '{4'hE, 4'h0, 4'hC, 4'h3, 4'h3, 4'hE};
   logic [3:0] f_tab[6] = '{4'h0, 4'h0, 4'h1, 4'h7, 4'h7, 4'h0};
   initial forever #2 ref_clk = ~ref_clk;
   prcr_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl_pin(scl), .sda_pin_in(sda_wire),
      .sda_pin_out(), .sda_pin_oe(sda_oe), .sys_mode_pin(sys_mode),
      .group_active_pin(grp_act), .warm_reset_pin(warm), .reset_output_state(rst_st),
      .main_ref_state(ref_st), .reset_output_vsel_restore(rst_vsel),
      .main_ref_vsel_restore(ref_vsel));
   prcr_host host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
   // Count restore pulses per resource
   always @(posedge ref_clk) begin
      if (rst_vsel === 1'b1) vsel_rst_cnt++;
      if (ref_vsel === 1'b1) vsel_ref_cnt++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic read_check(input logic [7:0] ptr, input logic [7:0] exp[$]);
      host.read_regs(ptr, exp.size(), q);
      foreach (exp[i]) check(q[i], exp[i]);
   endtask
   task automatic write_all(input logic [7:0] ptr, input logic [7:0] d[$]);
      host.write_regs(ptr, d, ok);
      check({7'h0, ok}, 8'h01);
   endtask
   task automatic set_pins(input logic [1:0] m, input logic [2:0] g);
      @(posedge ref_clk);
      sys_mode <= m;
      grp_act <= g;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      read_check(8'hEC, '{8'hE0, 8'h06, 8'h08});
      check(8'(vsel_rst_cnt + vsel_ref_cnt), 8'h00);
      read_check(8'hEF, '{8'hE0, 8'h00, 8'h08, 8'h00});
      write_all(8'hEC, '{7{8'hFF}});
      read_check(8'hEC, '{8'hF0, 8'h1F, 8'hFF, 8'hF0, 8'h1F, 8'hFF, 8'h00});
      write_all(8'hEC, '{8'h20, 8'h1D, 8'h3C, 8'h10, 8'h0A, 8'h71});
      read_check(8'hEC, '{8'h20, 8'h1D, 8'h3C, 8'h10, 8'h0A, 8'h71});
      for (int i = 0; i < 6; i++) begin
         set_pins(m_tab[i], g_tab[i]);
         check({rst_st, ref_st}, {r_tab[i], f_tab[i]});
      end
      set_pins(2'h1, 3'h0);
      write_all(8'hEC, '{8'h2F});
      read_check(8'hEC, '{8'h2C});
      set_pins(2'h0, 3'h0);
      @(posedge ref_clk);
      warm <= 1'b1;
      repeat (12) @(posedge ref_clk);
      warm <= 1'b0;
      repeat (12) @(posedge ref_clk);
      read_check(8'hEC, '{8'hE0});
      read_check(8'hEF, '{8'h10});
      check(8'(vsel_rst_cnt), 8'h01);
      check(8'(vsel_ref_cnt), 8'h01);
      give_verdict();
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end
endmodule
